/* File: core/ums_uart.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ums_cfg.svh"
module ums_uart
  import ums_pkg::*;
#(
  parameter int TXQ_DEPTH = 16
) (
  input wire logic clk_sys_i, // System clock, 250 MHz.
  input wire logic nrst_i, // Reset, active low.
  input wire logic [2:0] addr_i, // Register select.
  input wire logic wr_i, // Write strobe, one cycle.
  input wire logic rd_i, // Read strobe, one cycle.
  input wire logic [7:0] wdata_i, // Write data.
  output logic [7:0] rdata_o, // Read data, registered.
  output logic irq_o, // Interrupt level.
  output logic irq_oe_o, // Interrupt pin enable.
  output logic ser_out_o, // Serial output.
  input wire logic ser_in_i, // Serial input.
  input wire logic clear_to_send_in_n_i, // Modem input.
  input wire logic data_set_ready_in_n_i, // Modem input.
  input wire logic ring_indicator_in_n_i, // Modem input.
  input wire logic carrier_detect_in_n_i, // Modem input.
  output logic term_ready_out_n_o, // Modem output.
  output logic req_to_send_out_n_o, // Modem output.
  output logic soft_reset_o, // Software reset output.
  output logic power_down_o, // Oscillator stop request.
  output logic baud_tick_o // 16x baud enable pulse.
);
  // ****************************************
  // Reset and input synchronisers
  // ****************************************
  logic [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  // Five pins pass three flops; a change counts when stages two and three agree.
  wire [4:0] pins_raw = {carrier_detect_in_n_i, ring_indicator_in_n_i, data_set_ready_in_n_i,
                         clear_to_send_in_n_i, ser_in_i};
  logic [4:0] s1_reg, s2_reg, s3_reg, pin_reg;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 5'h1F;
      s2_reg <= 5'h1F;
      s3_reg <= 5'h1F;
      pin_reg <= 5'h1F;
    end else begin
      s1_reg <= pins_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg | s3_reg));
    end
  end
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] lcr_reg, mctl_reg, ier_reg, scr_reg, rbr_reg;
  logic [15:0] div_reg;
  logic [3:0] delta_reg, mstat_prev_reg;
  logic dr_reg, oe_reg, pe_reg, fe_reg, bi_reg;
  wire dlsel = lcr_reg[`UMS_LCR_DLSEL];
  wire loop = mctl_reg[`UMS_MC_LOOP];
  wire wr_data = wr_i && addr_i == `UMS_ADDR_DATA && !dlsel;
  wire wr_dll = wr_i && addr_i == `UMS_ADDR_DATA && dlsel;
  wire wr_dlm = wr_i && addr_i == `UMS_ADDR_IER && dlsel;
  wire wr_ier = wr_i && addr_i == `UMS_ADDR_IER && !dlsel;
  wire rd_rbr = rd_i && addr_i == `UMS_ADDR_DATA && !dlsel;
  wire rd_mst = rd_i && addr_i == `UMS_ADDR_MSTAT;
  wire rd_lst = rd_i && addr_i == `UMS_ADDR_LSTAT;
  // Modem status view: loop-back takes RTS, DTR, soft reset, irq enable.
  wire [3:0] mstat_now = loop ? {mctl_reg[`UMS_MC_IRQEN], mctl_reg[`UMS_MC_SRST],
                                 mctl_reg[`UMS_MC_TRDY], mctl_reg[`UMS_MC_RTS]}
                              : ~pin_reg[4:1];
  // Change detection, ring only on the input going low-to-high (status falling).
  wire [3:0] chg = mstat_now ^ mstat_prev_reg;
  wire [3:0] delta_set = {chg[3], chg[2] & ~mstat_now[2], chg[1], chg[0]};
  // Host-writable registers.
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      lcr_reg <= 8'h00;
      mctl_reg <= `UMS_MC_RESET;
      ier_reg <= 8'h00;
      scr_reg <= 8'h00;
      div_reg <= `UMS_DIV_RESET;
    end else if (wr_i) begin
      if (addr_i == `UMS_ADDR_LCR) lcr_reg <= wdata_i;
      if (addr_i == `UMS_ADDR_MCTL) mctl_reg <= wdata_i & `UMS_MC_RMASK;
      if (addr_i == `UMS_ADDR_SCR) scr_reg <= wdata_i;
      if (wr_ier) ier_reg <= wdata_i & `UMS_IER_RMASK;
      if (wr_dll) div_reg[7:0] <= wdata_i;
      if (wr_dlm) div_reg[15:8] <= wdata_i;
    end
  end
  // Delta bits: a new change wins over the clear by read.
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      delta_reg <= 4'h0;
      mstat_prev_reg <= 4'h0;
    end else begin
      mstat_prev_reg <= mstat_now;
      delta_reg <= (rd_mst ? 4'h0 : delta_reg) | delta_set;
    end
  end
  // ****************************************
  // Baud generator
  // ****************************************
  logic [15:0] bcnt_reg;
  logic tick_reg;
  wire pdown = mctl_reg[`UMS_MC_PDOWN];
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (pdown) begin
      bcnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (bcnt_reg + 16'h0001 >= div_reg);
      bcnt_reg <= (bcnt_reg + 16'h0001 >= div_reg) ? 16'h0000 : bcnt_reg + 16'h0001;
    end
  end
  // ****************************************
  // Transmitter with holding FIFO
  // ****************************************
  logic [7:0] q_data;
  logic q_valid, q_ready, q_pop;
  ums_fifo #(.WIDTH(8), .DEPTH(TXQ_DEPTH)) u_txq (
    .clk_i(clk_sys_i), .rst_n_i(rst_n), .in_data_i(wdata_i), .in_valid_i(wr_data),
    .in_ready_o(q_ready), .out_data_o(q_data), .out_valid_o(q_valid), .out_ready_i(q_pop)
  );
  ums_tx_state_t tx_st;
  logic [10:0] tsh_reg;
  logic [3:0] tbits_reg, tph_reg;
  logic tx_line_reg;
  // Word length is 5 to 8, so it needs four bits; the mask keeps only the data bits.
  wire [3:0] wl = {2'h0, lcr_reg[1:0]} + 4'h5;
  wire [7:0] dmask = 8'hFF >> (4'h8 - wl);
  wire par_bit = lcr_reg[`UMS_LCR_STICK] ? ~lcr_reg[`UMS_LCR_EVEN]
               : ^(q_data & dmask) ^ ~lcr_reg[`UMS_LCR_EVEN];
  assign q_pop = tx_st == UMS_TX_IDLE && tick_reg && q_valid;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_st <= UMS_TX_IDLE;
      tsh_reg <= 11'h7FF;
      tbits_reg <= 4'h0;
      tph_reg <= 4'h0;
      tx_line_reg <= 1'b1;
    end else if (tick_reg) begin
      unique case (tx_st)
        UMS_TX_IDLE: if (q_valid) begin
          tsh_reg <= 11'h7FF;
          tsh_reg[7:0] <= q_data | ~dmask; // Unused data bits become stop ones.
          tsh_reg[wl] <= lcr_reg[`UMS_LCR_PEN] ? par_bit : 1'b1;
          tbits_reg <= wl + (lcr_reg[`UMS_LCR_PEN] ? 4'h2 : 4'h1) + {3'h0, lcr_reg[`UMS_LCR_STOP]};
          tph_reg <= 4'h0;
          tx_line_reg <= 1'b0;
          tx_st <= UMS_TX_SHIFT;
        end
        UMS_TX_SHIFT: begin
          tph_reg <= tph_reg + 4'h1;
          if (tph_reg == 4'hF) begin
            tx_line_reg <= tsh_reg[0];
            tsh_reg <= {1'b1, tsh_reg[10:1]};
            tbits_reg <= tbits_reg - 4'h1;
            if (tbits_reg == 4'h0) begin
              tx_line_reg <= 1'b1;
              tx_st <= UMS_TX_IDLE;
            end
          end
        end
        default: tx_st <= UMS_TX_IDLE;
      endcase
    end
  end
  wire thr_empty = !q_valid;
  wire tx_empty = !q_valid && tx_st == UMS_TX_IDLE;
  // ****************************************
  // Receiver
  // ****************************************
  wire rx_line = loop ? tx_line_reg : pin_reg[0];
  ums_rx_state_t rx_st;
  logic [3:0] rph_reg, rcnt_reg;
  logic [9:0] rsh_reg;
  wire [3:0] rtotal = wl + {3'h0, lcr_reg[`UMS_LCR_PEN]} + 4'h1;
  wire [7:0] rdat = rsh_reg[7:0] & dmask;
  wire rpar = rsh_reg[wl];
  wire rpar_exp = lcr_reg[`UMS_LCR_STICK] ? ~lcr_reg[`UMS_LCR_EVEN] : ^rdat ^ ~lcr_reg[`UMS_LCR_EVEN];
  // The character ends at the stop sample, so a back-to-back start bit is not missed.
  wire rx_done = rx_st == UMS_RX_DATA && tick_reg && rph_reg == 4'hF && rcnt_reg == rtotal - 4'h1;
  wire stop_bit = rx_line;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_st <= UMS_RX_IDLE;
      rph_reg <= 4'h0;
      rcnt_reg <= 4'h0;
      rsh_reg <= 10'h000;
      rbr_reg <= 8'h00;
    end else if (tick_reg) begin
      unique case (rx_st)
        UMS_RX_IDLE: if (!rx_line) begin
          rph_reg <= 4'h0;
          rx_st <= UMS_RX_START;
        end
        UMS_RX_START: begin
          rph_reg <= rph_reg + 4'h1;
          if (rph_reg == `UMS_MID_SAMPLE) begin
            rph_reg <= 4'h0;
            rcnt_reg <= 4'h0;
            rx_st <= rx_line ? UMS_RX_IDLE : UMS_RX_DATA;
          end
        end
        UMS_RX_DATA: begin
          rph_reg <= rph_reg + 4'h1;
          if (rph_reg == 4'hF) begin
            rcnt_reg <= rcnt_reg + 4'h1;
            if (rcnt_reg < rtotal - 4'h1) rsh_reg[rcnt_reg] <= rx_line;
            if (rx_done) begin
              rbr_reg <= rdat;
              rx_st <= UMS_RX_IDLE;
            end
          end
        end
        default: rx_st <= UMS_RX_IDLE;
      endcase
    end
  end
  // Line status flags; a completing character wins over the clearing read.
  wire all_zero = (rdat == 8'h00) && !stop_bit && !(lcr_reg[`UMS_LCR_PEN] && rpar);
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      dr_reg <= 1'b0;
      oe_reg <= 1'b0;
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
      bi_reg <= 1'b0;
    end else begin
      dr_reg <= rx_done | (dr_reg & ~rd_rbr);
      oe_reg <= (rx_done & dr_reg & ~rd_rbr) | (oe_reg & ~rd_lst);
      pe_reg <= (rx_done & lcr_reg[`UMS_LCR_PEN] & (rpar != rpar_exp)) | (pe_reg & ~rd_lst);
      fe_reg <= (rx_done & ~stop_bit) | (fe_reg & ~rd_lst);
      bi_reg <= (rx_done & all_zero) | (bi_reg & ~rd_lst);
    end
  end
  // ****************************************
  // Interrupts, read mux, outputs
  // ****************************************
  wire [7:0] lstat = {1'b0, tx_empty, thr_empty, bi_reg, fe_reg, pe_reg, oe_reg, dr_reg};
  wire ls_irq = ier_reg[`UMS_IER_LS] && (oe_reg | pe_reg | fe_reg | bi_reg);
  wire rx_irq = ier_reg[`UMS_IER_RX] && dr_reg;
  wire tx_irq = ier_reg[`UMS_IER_TX] && thr_empty;
  wire ms_irq = ier_reg[`UMS_IER_MS] && (delta_reg != 4'h0);
  wire [7:0] irq_status_reg = ls_irq ? 8'h06 : rx_irq ? 8'h04 : tx_irq ? 8'h02 : ms_irq ? 8'h00 : `UMS_ISR_IDLE;
  wire [7:0] rd_mux = (addr_i == `UMS_ADDR_DATA) ? (dlsel ? div_reg[7:0] : rbr_reg)
                    : (addr_i == `UMS_ADDR_IER) ? (dlsel ? div_reg[15:8] : ier_reg)
                    : (addr_i == `UMS_ADDR_ISR) ? irq_status_reg
                    : (addr_i == `UMS_ADDR_LCR) ? lcr_reg
                    : (addr_i == `UMS_ADDR_MCTL) ? (mctl_reg & `UMS_MC_RMASK)
                    : (addr_i == `UMS_ADDR_LSTAT) ? lstat
                    : (addr_i == `UMS_ADDR_MSTAT) ? {mstat_now, delta_reg}
                    : scr_reg;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
      irq_o <= 1'b0;
      irq_oe_o <= 1'b0;
      ser_out_o <= 1'b1;
      term_ready_out_n_o <= 1'b1;
      req_to_send_out_n_o <= 1'b1;
      soft_reset_o <= 1'b1;
      power_down_o <= 1'b0;
      baud_tick_o <= 1'b0;
    end else begin
      if (rd_i) rdata_o <= rd_mux;
      irq_o <= ls_irq | rx_irq | tx_irq | ms_irq;
      irq_oe_o <= mctl_reg[`UMS_MC_IRQEN];
      ser_out_o <= loop ? 1'b1 : (tx_line_reg & ~lcr_reg[`UMS_LCR_BREAK]);
      term_ready_out_n_o <= loop | ~mctl_reg[`UMS_MC_TRDY];
      req_to_send_out_n_o <= loop | ~mctl_reg[`UMS_MC_RTS];
      soft_reset_o <= mctl_reg[`UMS_MC_SRST];
      power_down_o <= pdown;
      baud_tick_o <= tick_reg;
    end
  end
endmodule
`default_nettype wire

/* File: core/ums_cfg.svh */
`ifndef UMS_CFG_SVH
`define UMS_CFG_SVH
// Register addresses on the 3-bit register select (A2..A0).
`define UMS_ADDR_DATA 3'h0
`define UMS_ADDR_IER 3'h1
`define UMS_ADDR_ISR 3'h2
`define UMS_ADDR_LCR 3'h3
`define UMS_ADDR_MCTL 3'h4
`define UMS_ADDR_LSTAT 3'h5
`define UMS_ADDR_MSTAT 3'h6
`define UMS_ADDR_SCR 3'h7
// Field positions.
`define UMS_LCR_DLSEL 7
`define UMS_LCR_BREAK 6
`define UMS_LCR_STICK 5
`define UMS_LCR_EVEN 4
`define UMS_LCR_PEN 3
`define UMS_LCR_STOP 2
`define UMS_MC_TRDY 0
`define UMS_MC_RTS 1
`define UMS_MC_SRST 2
`define UMS_MC_IRQEN 3
`define UMS_MC_LOOP 4
`define UMS_MC_PDOWN 7
`define UMS_IER_RX 0
`define UMS_IER_TX 1
`define UMS_IER_LS 2
`define UMS_IER_MS 3
// Reset values and read masks.
`define UMS_MC_RESET 8'h00
`define UMS_MC_RMASK 8'h9F
`define UMS_IER_RMASK 8'h2F
`define UMS_ISR_IDLE 8'h01
`define UMS_DIV_RESET 16'h0001
// Receiver samples the start bit at the middle of the 16x clock.
`define UMS_MID_SAMPLE 4'h7
`endif

/* File: core/ums_pkg.sv */
package ums_pkg;
  typedef enum logic [1:0] {UMS_TX_IDLE, UMS_TX_SHIFT} ums_tx_state_t;
  typedef enum logic [1:0] {UMS_RX_IDLE, UMS_RX_START, UMS_RX_DATA} ums_rx_state_t;
endpackage

/* File: core/ums_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
// Small synchronous FIFO with valid/ready on both sides.
module ums_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i, // Clock.
  input wire logic rst_n_i, // Synchronised reset, active low.
  input wire logic [WIDTH-1:0] in_data_i, // Write data.
  input wire logic in_valid_i, // Write request.
  output logic in_ready_o, // Not full.
  output logic [WIDTH-1:0] out_data_o, // Head word.
  output logic out_valid_o, // Not empty.
  input wire logic out_ready_i // Pop request.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  // Flags come straight from the occupancy count.
  assign in_ready_o = (cnt_reg != DEPTH[AW:0]);
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rd_reg];
  // Storage array.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end
  // Pointers and count.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* File: tb/ums_uart_checker.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ums_cfg.svh"
// ****************************************
// Port checker for the UART register block
// ****************************************
module ums_uart_checker (
  input wire logic clk_sys_i, // Clock.
  input wire logic nrst_i, // Reset, active low.
  input wire logic [2:0] addr_i, // Register select.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  input wire logic [7:0] wdata_i, // Write data.
  input wire logic [7:0] rdata_o, // Read data.
  input wire logic irq_oe_o, // Interrupt pin enable.
  input wire logic ser_out_o, // Serial output.
  input wire logic term_ready_out_n_o, // Terminal ready.
  input wire logic req_to_send_out_n_o, // Request to send.
  input wire logic soft_reset_o, // Software reset.
  input wire logic power_down_o // Power down.
);
  logic [7:0] mc_reg;
  logic [3:0] quiet_reg;
  wire logic mc_wr = wr_i && addr_i == `UMS_ADDR_MCTL;
  wire logic settled = quiet_reg >= 4'h6;
  // Shadow of the control byte and a saturating count of cycles since it was written.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mc_reg <= 8'h00;
      quiet_reg <= 4'h0;
    end else begin
      mc_reg <= mc_wr ? wdata_i : mc_reg;
      quiet_reg <= mc_wr ? 4'h0 : (quiet_reg == 4'hF ? quiet_reg : quiet_reg + 4'h1);
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence mc_read_s;
    rd_i && addr_i == `UMS_ADDR_MCTL && quiet_reg != 4'h0;
  endsequence
  sequence loop_msr_read_s;
    rd_i && addr_i == `UMS_ADDR_MSTAT && mc_reg[4] && settled;
  endsequence
  // Output pins follow the control byte once it has settled.
  dtr_level_a: assert property (settled |-> term_ready_out_n_o == !(mc_reg[0] && !mc_reg[4]))
    else $error("terminal ready pin disagrees with control byte");
  rts_level_a: assert property (settled |-> req_to_send_out_n_o == !(mc_reg[1] && !mc_reg[4]))
    else $error("request to send pin disagrees with control byte");
  soft_reset_a: assert property (settled |-> soft_reset_o == mc_reg[2])
    else $error("software reset pin disagrees with control byte");
  irq_pin_a: assert property (settled |-> irq_oe_o == mc_reg[3])
    else $error("interrupt pin enable disagrees with control byte");
  power_down_a: assert property (settled |-> power_down_o == mc_reg[7])
    else $error("power down pin disagrees with control byte");
  loop_mark_a: assert property (settled && mc_reg[4] |-> ser_out_o)
    else $error("serial output not at mark in loop-back");
  ctl_readback_a: assert property (mc_read_s |=> rdata_o == (mc_reg & 8'h9F))
    else $error("control byte read back wrong");
  lsr_top_a: assert property (rd_i && addr_i == `UMS_ADDR_LSTAT |=> !rdata_o[7])
    else $error("line status top bit set");
  loop_status_a: assert property (loop_msr_read_s |=> rdata_o[7:4] == {mc_reg[3], mc_reg[2], mc_reg[0], mc_reg[1]})
    else $error("looped modem status bits wrong");
endmodule
bind ums_uart ums_uart_checker chk_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i),
  .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .irq_oe_o(irq_oe_o), .ser_out_o(ser_out_o),
  .term_ready_out_n_o(term_ready_out_n_o), .req_to_send_out_n_o(req_to_send_out_n_o),
  .soft_reset_o(soft_reset_o), .power_down_o(power_down_o));
`default_nettype wire

/* File: tb/ums_modem_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Modem peripheral on the serial side
// ****************************************
module ums_modem_model (
  input wire logic clk_i, // Clock.
  input wire logic [3:0] lines_i, // Wanted levels {cd, ri, dsr, cts}, active low.
  input wire logic break_i, // Hold the serial line low.
  output logic carrier_detect_n_o, // Carrier detect.
  output logic ring_indicator_n_o, // Ring indicator.
  output logic data_set_ready_n_o, // Data set ready.
  output logic clear_to_send_n_o, // Clear to send.
  output logic ser_line_o // Serial line, idle high.
);
  // Lines start inactive and the line idles at mark.
  initial begin
    {carrier_detect_n_o, ring_indicator_n_o, data_set_ready_n_o, clear_to_send_n_o} = 4'hF;
    ser_line_o = 1'b1;
  end
  // The peripheral changes its lines just after a clock edge.
  always @(posedge clk_i) begin
    {carrier_detect_n_o, ring_indicator_n_o, data_set_ready_n_o, clear_to_send_n_o} <= lines_i;
    ser_line_o <= !break_i;
  end
endmodule
`default_nettype wire

/* File: tb/uart_modem_line_status_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ums_cfg.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
// ****************************************
// Testbench
// ****************************************
module uart_modem_line_status_tb;
  typedef struct packed {logic [7:0] wv; logic [4:0] pins; logic [7:0] rb;} ums_mc_row_t;
  ums_mc_row_t mc_rows [6] = '{'{8'h00, 5'h03, 8'h00}, '{8'h01, 5'h02, 8'h01}, '{8'h02, 5'h01, 8'h02},
    '{8'h04, 5'h07, 8'h04}, '{8'h08, 5'h0B, 8'h08}, '{8'hE3, 5'h10, 8'h83}};
  logic [11:0] ms_rows [7] = '{12'hF00, 12'hE11, 12'hE10, 12'h4BA, 12'h0F0, 12'h4B4, 12'hF0B};
  logic [7:0] scr_vals [4] = '{8'hFF, 8'hA5, 8'h5A, 8'h00};
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic brk = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [3:0] lines = 4'hF;
  logic [7:0] rdata_o;
  logic irq_o, irq_oe_o, ser_out_o, ser_in_i, cts_n, dsr_n, ri_n, cd_n;
  logic dtr_n, rts_n, srst, pdown;
  int miscompares = 0;
  int samples_checked = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  ums_uart #(.TXQ_DEPTH(16)) dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i),
    .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o),
    .ser_out_o(ser_out_o), .ser_in_i(ser_in_i), .clear_to_send_in_n_i(cts_n), .data_set_ready_in_n_i(dsr_n),
    .ring_indicator_in_n_i(ri_n), .carrier_detect_in_n_i(cd_n), .term_ready_out_n_o(dtr_n),
    .req_to_send_out_n_o(rts_n), .soft_reset_o(srst), .power_down_o(pdown), .baud_tick_o());
  ums_modem_model model_u (.clk_i(clk_sys_i), .lines_i(lines), .break_i(brk), .carrier_detect_n_o(cd_n),
    .ring_indicator_n_o(ri_n), .data_set_ready_n_o(dsr_n), .clear_to_send_n_o(cts_n), .ser_line_o(ser_in_i));
  // Prints the verdict and ends the run.
  task automatic conclude();
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One write cycle on the register bus.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  // One read cycle; the data is compared once it has landed.
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    `CHK(rdata_o, e)
  endtask
  // Cuts a hung run short.
  initial begin
    #(40000 * 4);
    miscompares++;
    conclude();
  end
  // Main sequence: tables first, then loop-back, serial and break cases.
  initial begin
    repeat (8) @(posedge clk_sys_i);
    `CHK({ser_out_o, dtr_n, rts_n, srst, irq_oe_o}, 5'h1E)
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd_chk(`UMS_ADDR_LSTAT, 8'h60);
    rd_chk(`UMS_ADDR_ISR, 8'h01);
    rd_chk(`UMS_ADDR_MCTL, 8'h00);
    foreach (mc_rows[i]) begin
      wr(`UMS_ADDR_MCTL, mc_rows[i].wv);
      repeat (6) @(posedge clk_sys_i);
      #1;
      `CHK({pdown, irq_oe_o, srst, rts_n, dtr_n}, mc_rows[i].pins)
      rd_chk(`UMS_ADDR_MCTL, mc_rows[i].rb);
    end
    foreach (scr_vals[i]) begin
      wr(`UMS_ADDR_SCR, scr_vals[i]);
      rd_chk(`UMS_ADDR_SCR, scr_vals[i]);
    end
    wr(`UMS_ADDR_MCTL, 8'h00);
    wr(`UMS_ADDR_IER, 8'h08);
    foreach (ms_rows[i]) begin
      @(posedge clk_sys_i);
      lines <= ms_rows[i][11:8];
      repeat (12) @(posedge clk_sys_i);
      #1;
      `CHK(irq_o, |ms_rows[i][3:0])
      rd_chk(`UMS_ADDR_MSTAT, ms_rows[i][7:0]);
    end
    wr(`UMS_ADDR_LCR, 8'h80);
    wr(`UMS_ADDR_DATA, 8'h01);
    wr(`UMS_ADDR_IER, 8'h00);
    rd_chk(`UMS_ADDR_IER, 8'h00);
    rd_chk(`UMS_ADDR_DATA, 8'h01);
    wr(`UMS_ADDR_LCR, 8'h03);
    rd_chk(`UMS_ADDR_IER, 8'h08);
    wr(`UMS_ADDR_MCTL, 8'h1F);
    brk <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    #1;
    `CHK(irq_o, 1'b1)
    rd_chk(`UMS_ADDR_MSTAT, 8'hFB);
    @(posedge clk_sys_i);
    lines <= 4'hA;
    repeat (20) @(posedge clk_sys_i);
    rd_chk(`UMS_ADDR_MSTAT, 8'hF0);
    wr(`UMS_ADDR_DATA, 8'hA5);
    repeat (400) @(posedge clk_sys_i);
    rd_chk(`UMS_ADDR_LSTAT, 8'h61);
    rd_chk(`UMS_ADDR_DATA, 8'hA5);
    rd_chk(`UMS_ADDR_LSTAT, 8'h60);
    for (int i = 0; i < 18; i++) wr(`UMS_ADDR_DATA, 8'h10 + 8'(i));
    rd_chk(`UMS_ADDR_LSTAT, 8'h00);
    repeat (2800) @(posedge clk_sys_i);
    rd_chk(`UMS_ADDR_LSTAT, 8'h63);
    rd_chk(`UMS_ADDR_LSTAT, 8'h61);
    wr(`UMS_ADDR_LCR, 8'h0B);
    wr(`UMS_ADDR_MCTL, 8'h00);
    repeat (400) @(posedge clk_sys_i);
    brk <= 1'b0;
    repeat (200) @(posedge clk_sys_i);
    rd_chk(`UMS_ADDR_LSTAT, 8'h7F);
    conclude();
  end
endmodule
`default_nettype wire
